// >>> shared/iblc_pkg.sv
// Package of constants for the in-band loop code generator and detector
package iblc_pkg;
  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0] ADDR_LEN_CTRL = 8'h12;
  localparam logic [7:0] ADDR_TX_PAT   = 8'h13;
  localparam logic [7:0] ADDR_UP_PAT   = 8'h14;
  localparam logic [7:0] ADDR_DN_PAT   = 8'h15;
  localparam logic [7:0] ADDR_CTRL     = 8'h16;
  localparam logic [7:0] ADDR_STATUS   = 8'h17;
  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int TX_LEN_HI    = 7;
  localparam int TX_LEN_LO    = 6;
  localparam int UP_LEN_HI    = 5;
  localparam int UP_LEN_LO    = 3;
  localparam int DN_LEN_HI    = 2;
  localparam int DN_LEN_LO    = 0;
  localparam int CTRL_TX_EN   = 1;
  localparam int CTRL_NO_FBIT = 0;
  localparam int STAT_UP      = 7;
  localparam int STAT_DN      = 6;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int FRAME_BITS    = 193;
  localparam int CLK_HZ        = 10000000;
  localparam int INTEG_MS      = 48;
  localparam int INTEG_CYCLES  = INTEG_MS * (CLK_HZ / 1000);
  localparam int MISS_DIV      = 4;
endpackage : iblc_pkg

// >>> test/iblc_far_end.sv
// Far-end line equipment model sending repeating loop codes
`timescale 1ns/100ps
module iblc_far_end (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       send,
  input  wire logic       framed,
  input  wire logic [7:0] pat,
  input  wire logic [3:0] len,
  output logic            rx_bit_en,
  output logic            rx_data
);
  logic [1:0] div_r;
  logic [2:0] pos_r;
  logic [7:0] frm_r;
  logic [6:0] err_r;
  wire        bit_w  = (div_r == 2'h3);
  wire        last_w = ({1'b0, pos_r} >= len - 4'h1);
  // One line bit every four clocks; idle line toggles so it never looks like an odd-length code
  always_ff @(posedge clock) begin
    div_r     <= srst ? 2'h0 : div_r + 2'h1;
    rx_bit_en <= !srst && bit_w;
    if (srst) begin
      pos_r   <= 3'h0;
      frm_r   <= 8'h00;
      err_r   <= 7'h00;
      rx_data <= 1'b0;
    end else if (bit_w) begin
      frm_r <= (frm_r == 8'hc0) ? 8'h00 : frm_r + 8'h01;
      err_r <= (err_r == 7'h63) ? 7'h00 : err_r + 7'h01;
      pos_r <= (!send || last_w) ? 3'h0 : pos_r + 3'h1;
      // one bit in 100 wrong, F slot every 193 bits when framed
      rx_data <= send ? pat[3'h7 - pos_r] ^ (err_r == 7'h00) ^ (framed && frm_r == 8'h00)
                      : ~rx_data;
    end
  end
endmodule // iblc_far_end

// >>> test/inband_loop_code_gen_det_test.sv
// Self-checking bench for the in-band loop code block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module inband_loop_code_gen_det_test;
  typedef struct { logic [7:0] a, d, ex; } iblc_row_t;
  logic       clock = 0, srst = 1, reg_wr = 0, reg_rd = 0, send = 0, framed = 0, ce = 1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, fe_pat = 8'h00;
  logic [3:0] fe_len = 4'h1;
  logic       tx_bit_en = 0, tx_data = 0, tx_fbit_slot = 0, tx_fbit = 0;
  wire  [7:0] reg_rdata;
  wire        tx_out, rx_bit_en, rx_data, up_det, dn_det;
  int         bad_count = 0, n_compared = 0, cyc = 0;
  // Register rows: address, write value, read-back; status and unmapped stay zero
  iblc_row_t  rows [7] = '{'{8'h12, 8'h5a, 8'h5a}, '{8'h13, 8'ha5, 8'ha5},
    '{8'h14, 8'h3c, 8'h3c}, '{8'h15, 8'hc3, 8'hc3}, '{8'h16, 8'h03, 8'h03},
    '{8'h17, 8'hff, 8'h00}, '{8'h20, 8'hff, 8'h00}};
  // Low pattern bits set on purpose: they must never reach the line
  logic [1:0] t_code [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  int         t_len  [4] = '{5, 6, 7, 8};
  logic [7:0] t_pat  [4] = '{8'h87, 8'hb7, 8'hd9, 8'h96};

  iblc_top #(.INTEG(2000)) uut (.clock(clock), .srst(srst), .ce(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_bit_en(tx_bit_en), .tx_data(tx_data), .tx_fbit_slot(tx_fbit_slot),
    .tx_fbit(tx_fbit), .tx_out(tx_out), .rx_bit_en(rx_bit_en), .rx_data(rx_data),
    .up_code_detected(up_det), .down_code_detected(dn_det));
  iblc_far_end fe (.clock(clock), .srst(srst), .send(send), .framed(framed), .pat(fe_pat),
    .len(fe_len), .rx_bit_en(rx_bit_en), .rx_data(rx_data));

  // ***********************************
  // Clock, timeout and bus tasks
  // ***********************************
  initial begin
    forever #50 clock = ~clock;
  end
  // Ceiling well above the roughly 12700 cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clock);
    srst = 1;
    repeat (8) @(negedge clock);
    srst = 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    @(negedge clock);
    reg_rd = 1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 0;
    `CHK("reg_rdata", ex, reg_rdata)
  endtask
  // F slot on bit 9 carries the inverse of the pattern bit, so a miss shows
  task automatic tx_run(input logic [7:0] pat, input int len, input logic nof);
    int   p;
    logic ex;
    p = 0;
    for (int k = 0; k < 24; k++) begin
      @(negedge clock);
      tx_bit_en = 1;
      tx_fbit_slot = (k == 9);
      tx_fbit = ~pat[7 - p];
      ex = pat[7 - p];
      if (k == 9 && !nof) ex = tx_fbit;
      else p = (p + 1) % len;
      @(negedge clock);
      tx_bit_en = 0;
      tx_fbit_slot = 0;
      `CHK("tx_out", ex, tx_out)
    end
  endtask

  // ***********************************
  // Main sequence
  // ***********************************
  initial begin
    do_reset();
    `CHK("flags", 2'b00, {up_det, dn_det})
    for (int i = 0; i < 7; i++) begin
      rd(rows[i].a, iblc_pkg::REG_RESET);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].ex);
    end
    for (int i = 0; i < 4; i++) begin
      do_reset();
      wr(8'h12, {t_code[i], 6'h00});
      wr(8'h13, t_pat[i]);
      wr(8'h16, 8'h02);
      tx_run(t_pat[i], t_len[i], 1'b0);
    end
    do_reset();
    wr(8'h12, 8'hc0);
    wr(8'h13, 8'hff);
    wr(8'h16, 8'h03);
    tx_run(8'hff, 8, 1'b1);
    wr(8'h16, 8'h00);
    for (int k = 0; k < 2; k++) begin
      @(negedge clock);
      tx_bit_en = 1;
      tx_data = k[0];
      @(negedge clock);
      tx_bit_en = 0;
      `CHK("tx_out", k[0], tx_out)
    end
    // Clock enable low: a write and a transmit bit must both be held off
    ce = 0;
    wr(8'h13, 8'h00);
    @(negedge clock);
    tx_bit_en = 1;
    tx_data = 0;
    @(negedge clock);
    tx_bit_en = 0;
    ce = 1;
    `CHK("tx_out", 1'b1, tx_out)
    rd(8'h13, 8'hff);
    // Up code 5 bits unframed, then down code 3 bits framed, then idle line
    do_reset();
    wr(8'h12, 8'h22);
    wr(8'h14, 8'h87);
    wr(8'h15, 8'h9f);
    fe_pat = 8'h87;
    fe_len = 4'h5;
    send = 1;
    repeat (1000) @(negedge clock);
    `CHK("up_code_detected", 1'b0, up_det)
    repeat (3100) @(negedge clock);
    `CHK("flags", 2'b10, {up_det, dn_det})
    rd(8'h17, 8'h80);
    fe_pat = 8'h9f;
    fe_len = 4'h3;
    framed = 1;
    repeat (4100) @(negedge clock);
    `CHK("flags", 2'b01, {up_det, dn_det})
    rd(8'h17, 8'h40);
    send = 0;
    repeat (4100) @(negedge clock);
    rd(8'h17, 8'h00);
    finish_test();
  end
endmodule // inband_loop_code_gen_det_test

// >>> verilog/iblc_detector.sv
// Repeating code detector with error-tolerant integration
`timescale 1ns/100ps
module iblc_detector #(
  parameter int INTEG = 480000
) (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       bit_vld,
  input  wire logic [7:0] hist,
  input  wire logic [7:0] pattern,
  input  wire logic [2:0] len_fld,
  input  wire logic       tick,
  output logic            found
);
  // Counters sized to hold one full window of bits
  localparam int CW = $clog2(INTEG + 1);

  logic          hit;
  logic [CW-1:0] good_r;
  logic [CW-1:0] bad_r;

  // any rotation matches, so the code phase on the line never matters
  function automatic logic rot_hit(input logic [7:0] h,
                                   input logic [7:0] p,
                                   input logic [2:0] lf);
    logic [7:0] m;
    logic [7:0] r_v;
    logic       any;
    m   = 8'hff >> (3'd7 - lf);
    r_v = (p >> (3'd7 - lf)) & m;
    any = 1'b0;
    for (int r = 0; r < 8; r++) begin
      if (((h ^ r_v) & m) == 8'h00) any = 1'b1;
      r_v = ((r_v << 1) | (r_v >> lf)) & m;
    end
    return any;
  endfunction

  // field plus one bits, only leading pattern bits compared
  assign hit = rot_hit(hist, pattern, len_fld);

  // verdict per window; misses tolerated while below a quarter of hits
  always_ff @(posedge clock) begin
    if (srst) begin
      good_r <= '0;
      bad_r  <= '0;
      found  <= 1'b0;
    end else if (ce) begin
      if (bit_vld) begin
        if (hit) good_r <= good_r + CW'(1);
        else     bad_r  <= bad_r + CW'(1);
      end
      if (tick) begin
        good_r <= '0;
        bad_r  <= '0;
        found  <= ({2'b00, good_r} > {bad_r, 2'b00}) && (good_r != '0);
      end
    end
  end
endmodule : iblc_detector

// >>> verilog/iblc_top.sv
// In-band loop code generator and dual detector
// Overview of operation
// - Loop transmit enable sends the programmed pattern in place of data.
// - F-bit takes the F slot once per 193 bits unless disabled; the pattern is held across it.
// - Two-bit transmit field picks 5, 6/3, 7 or 8/4/2/1 bits.
// - Pattern bit 7 sent first; bits past length ignored.
// - Up length in bits 5..3, down length in bits 2..0.
// - Receive length is field value plus one, 1 to 8 bits.
// - Receive pattern bit 7 is first; bits past length not compared.
// - Detectors work framed or unframed, tolerating 1e-2 bit errors.
// - After about 48 ms of code, up or down status flag sets.
`timescale 1ns/100ps
module iblc_top #(
  parameter int INTEG = iblc_pkg::INTEG_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       tx_bit_en,
  input  wire logic       tx_data,
  input  wire logic       tx_fbit_slot,
  input  wire logic       tx_fbit,
  output logic            tx_out,
  input  wire logic       rx_bit_en,
  input  wire logic       rx_data,
  output logic            up_code_detected,
  output logic            down_code_detected
);
  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [7:0]  len_ctrl_r;
  logic [7:0]  tx_pat_r;
  logic [7:0]  up_pat_r;
  logic [7:0]  dn_pat_r;
  logic [1:0]  ctrl_r;
  logic [2:0]  tx_pos_r;
  logic [7:0]  hist_r;
  logic [31:0] win_r;
  logic        tick_r;
  logic        up_found;
  logic        dn_found;
  logic [2:0]  tx_last;
  logic        tx_pat_bit;
  logic        tx_nxt;
  logic [7:0]  rd_nxt;
  logic [1:0]  tx_len_sel;
  logic        loop_code_transmit_enable;
  logic        no_fbit;

  assign tx_len_sel                = len_ctrl_r[iblc_pkg::TX_LEN_HI:iblc_pkg::TX_LEN_LO];
  assign loop_code_transmit_enable = ctrl_r[iblc_pkg::CTRL_TX_EN];
  assign no_fbit                   = ctrl_r[iblc_pkg::CTRL_NO_FBIT];

  // Host writes; no write effect beyond storing
  always_ff @(posedge clock) begin
    if (srst) begin
      len_ctrl_r <= iblc_pkg::REG_RESET;
      tx_pat_r   <= iblc_pkg::REG_RESET;
      up_pat_r   <= iblc_pkg::REG_RESET;
      dn_pat_r   <= iblc_pkg::REG_RESET;
      ctrl_r     <= 2'b00;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        iblc_pkg::ADDR_LEN_CTRL: len_ctrl_r <= reg_wdata;
        iblc_pkg::ADDR_TX_PAT:   tx_pat_r   <= reg_wdata;
        iblc_pkg::ADDR_UP_PAT:   up_pat_r   <= reg_wdata;
        iblc_pkg::ADDR_DN_PAT:   dn_pat_r   <= reg_wdata;
        iblc_pkg::ADDR_CTRL:     ctrl_r     <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      iblc_pkg::ADDR_LEN_CTRL: rd_nxt = len_ctrl_r;
      iblc_pkg::ADDR_TX_PAT:   rd_nxt = tx_pat_r;
      iblc_pkg::ADDR_UP_PAT:   rd_nxt = up_pat_r;
      iblc_pkg::ADDR_DN_PAT:   rd_nxt = dn_pat_r;
      iblc_pkg::ADDR_CTRL:     rd_nxt = {6'h00, ctrl_r};
      iblc_pkg::ADDR_STATUS:   rd_nxt = {up_code_detected, down_code_detected, 6'h00};
      default:                 rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) reg_rdata <= 8'h00;
    else if (ce && reg_rd) reg_rdata <= rd_nxt;
  end

  // ***************************************************************
  // Transmit generator
  // ***************************************************************
  // length select
  // Short codes repeat inside the longer slot, so 8 bits covers 4/2/1
  always_comb begin
    case (tx_len_sel)
      2'b00:   tx_last = 3'd4;
      2'b01:   tx_last = 3'd5;
      2'b10:   tx_last = 3'd6;
      default: tx_last = 3'd7;
    endcase
  end

  // bit 7 first, low bits past length never reached
  assign tx_pat_bit = tx_pat_r[3'd7 - tx_pos_r];

  // pattern replaces data, F-bit kept unless disabled
  always_comb begin
    tx_nxt = tx_data;
    if (loop_code_transmit_enable) tx_nxt = tx_pat_bit;
    if (loop_code_transmit_enable && tx_fbit_slot && !no_fbit) tx_nxt = tx_fbit;
  end

  // pattern position skips the F-bit slot
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_pos_r <= 3'd0;
      tx_out   <= 1'b0;
    end else if (ce && tx_bit_en) begin
      tx_out <= tx_nxt;
      if (!loop_code_transmit_enable) tx_pos_r <= 3'd0;
      else if (!(tx_fbit_slot && !no_fbit))
        tx_pos_r <= (tx_pos_r >= tx_last) ? 3'd0 : tx_pos_r + 3'd1;  // Shortened length recovers
    end
  end

  // ***************************************************************
  // Receive detectors
  // ***************************************************************
  // history of every received bit, framing bits included
  always_ff @(posedge clock) begin
    if (srst) hist_r <= 8'h00;
    else if (ce && rx_bit_en) hist_r <= {hist_r[6:0], rx_data};
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      win_r  <= '0;
      tick_r <= 1'b0;
    end else if (ce) begin
      tick_r <= (win_r == 32'(INTEG - 1));
      win_r  <= (win_r == 32'(INTEG - 1)) ? '0 : win_r + 32'h1;
    end
  end

  iblc_detector #(.INTEG(INTEG)) u_up (
    .clock   (clock),
    .srst    (srst),
    .ce      (ce),
    .bit_vld (rx_bit_en),
    .hist    (hist_r),
    .pattern (up_pat_r),
    .len_fld (len_ctrl_r[iblc_pkg::UP_LEN_HI:iblc_pkg::UP_LEN_LO]),
    .tick    (tick_r),
    .found   (up_found)
  );

  iblc_detector #(.INTEG(INTEG)) u_dn (
    .clock   (clock),
    .srst    (srst),
    .ce      (ce),
    .bit_vld (rx_bit_en),
    .hist    (hist_r),
    .pattern (dn_pat_r),
    .len_fld (len_ctrl_r[iblc_pkg::DN_LEN_HI:iblc_pkg::DN_LEN_LO]),
    .tick    (tick_r),
    .found   (dn_found)
  );

  // flags follow detector verdict each window
  always_ff @(posedge clock) begin
    if (srst) begin
      up_code_detected   <= 1'b0;
      down_code_detected <= 1'b0;
    end else if (ce) begin
      up_code_detected   <= up_found;
      down_code_detected <= dn_found;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  // transmit carries pattern when enabled off F slot
  a_tx_pattern: assert property (@(posedge clock) disable iff (srst)
    ce && tx_bit_en && loop_code_transmit_enable && !tx_fbit_slot
      |=> tx_out == $past(tx_pat_bit))
    else $error("pattern not sent");
  a_fbit_insert: assert property (@(posedge clock) disable iff (srst)
    ce && tx_bit_en && loop_code_transmit_enable && tx_fbit_slot && !no_fbit
      |=> tx_out == $past(tx_fbit))
    else $error("F-bit lost");
  a_tx_bypass: assert property (@(posedge clock) disable iff (srst)
    ce && tx_bit_en && !loop_code_transmit_enable |=> tx_out == $past(tx_data))
    else $error("data not passed");
  a_tx_pos_range: assert property (@(posedge clock) disable iff (srst)
    ce && tx_bit_en && loop_code_transmit_enable && !(tx_fbit_slot && !no_fbit)
      |=> tx_pos_r <= $past(tx_last))
    else $error("position out of range");
  // wrap to first bit after last
  a_tx_wrap: assert property (@(posedge clock) disable iff (srst)
    ce && tx_bit_en && loop_code_transmit_enable && !tx_fbit_slot && tx_pos_r == tx_last
      |=> tx_pos_r == 3'd0)
    else $error("pattern did not wrap");
  // up flag rises and down flag falls only after a window tick
  a_flag_on_tick: assert property (@(posedge clock) disable iff (srst)
    $rose(up_code_detected) |-> $past(tick_r, 2))
    else $error("up flag off tick");
  a_flag_clear: assert property (@(posedge clock) disable iff (srst)
    $fell(down_code_detected) |-> $past(tick_r, 2))
    else $error("down flag off tick");
  a_status_read: assert property (@(posedge clock) disable iff (srst)
    ce && reg_rd && reg_addr == iblc_pkg::ADDR_STATUS
      |=> reg_rdata[7:6] == $past({up_code_detected, down_code_detected}))
    else $error("status read wrong");
endmodule : iblc_top
